/* rtl/sfcfe_top.sv */
// Functional notes
// - Input line sampled on serial clock rise, most significant bit first.
// - Select fall starts an instruction and clears bit and byte counters.
// - First byte after select fall is the opcode; it steers the rest.
// - Select rise ends the current instruction.
// - Reads may end after any bit; output stops at once.
// - Write, program and erase run only if select rises on a byte boundary.
// - While busy, only read status is accepted.
// - Exactly fifteen opcodes known; anything else does nothing.
// - Latch set, latch clear, status read/write, power-down and release decode.
// - Read, sector and block erase and program take three address bytes, high first; chip erase takes none.
// - Fast and dual reads add one dummy byte; program takes up to 256 bytes.
// - Returned bytes leave on the output line, most significant bit first; dual read uses both lines.
// - Status read repeats the live status byte until select rises.
// - After three dummies, release returns device code repeatedly.
// - Maker/device read and three-byte identity read return fixed codes.
// - Latch-set opcode sets the write latch when select rises.
// - Program, erase and status write need the write latch set.
// - Dense part guards 1/64 to 1/2 from top or bottom; 111 all.
// - Small part guards 1/32 to 1/2; 11x all, 000 none.
// - Write latch clears when a program, erase or status write ends.
// - Busy reads one for the whole program, erase or status write.
// - Lock bit plus low protect pin refuse status writes.
// - Status byte: busy, latch, protect field, low-end select, zero, lock.
`timescale 1ns/1ps
module sfcfe_top #(
  parameter logic [7:0] MAKER_CODE  = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] TYPE_CODE   = 8'h71, // Arbitrary value
  parameter logic [7:0] CAP_CODE    = 8'h17, // Arbitrary value
  parameter int         PAGE_BYTES  = 256
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         sclk,
  input  wire logic         cs_b,
  input  wire logic         serial_in_io_i,
  output logic              serial_in_io_o,
  output logic              serial_in_io_oe,
  output logic              serial_out_o,
  output logic              serial_out_oe,
  input  wire logic         write_protect_b,
  input  wire logic         dens_32m,
  input  wire logic         op_done,
  output logic              op_start,
  output sfcfe_pkg::sfcfe_op_t op_kind,
  output logic [23:0]       op_addr,
  output logic              prog_valid,
  output logic [7:0]        prog_data,
  output logic [23:0]       array_addr,
  input  wire logic [7:0]   array_data,
  output logic [7:0]        status_byte,
  output logic              power_down
);
  import sfcfe_pkg::*;

  localparam int PW = $clog2(PAGE_BYTES + 1);

  typedef struct packed {
    sfcfe_state_t st;
    logic [2:0]   bitc;
    logic [2:0]   bytec;
    logic [7:0]   opc;
    logic [7:0]   shin;
    logic [7:0]   shout;
    logic [7:0]   wdata;
    logic [23:0]  addr;
    logic [2:0]   obit;
    logic [1:0]   idx;
    logic         dout;
    logic         serial_in_io;
    logic         oe;
    logic         dual;
    logic         pend;
    logic         wl;
    logic         busy;
    logic         lock;
    logic         low_end;
    logic [2:0]   prot;
    logic         pd;
    logic         start;
    sfcfe_op_t    kind;
    logic         pvalid;
    logic [7:0]   pdata;
    logic [PW-1:0] pcnt;
  } sfcfe_core_t;

  sfcfe_core_t r;
  sfcfe_core_t next_r;
  sfcfe_link_if lk ();

  logic [7:0] shin_n;
  logic [7:0] stat;
  logic [7:0] nbyte;
  logic [2:0] bn;
  logic       ok;
  logic       go_out;
  logic       do_start;
  sfcfe_op_t  kind_v;
  logic       prot_hit;

  sfcfe_pin_sync u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .sclk    (sclk),
    .cs_b    (cs_b),
    .din_pin (serial_in_io_i),
    .wp_pin  (write_protect_b),
    .lk      (lk.src)
  );

  sfcfe_protect u_prot (
    .addr     (r.addr),
    .prot     (r.prot),
    .low_end  (r.low_end),
    .dens_32m (dens_32m),
    .chip     (r.opc == OPC_CHIP_ER),
    .hit      (prot_hit)
  );

  // ----------------------------------------
  // Status and outgoing byte
  // ----------------------------------------
  always_comb begin
    stat = 8'h00;
    stat[ST_BUSY] = r.busy;
    stat[ST_WL] = r.wl;
    stat[ST_PROT_HI:ST_PROT_LO] = r.prot;
    stat[ST_LOW_END] = r.low_end;
    stat[ST_LOCK] = r.lock;
    case (r.opc)
      OPC_RD_STAT:  nbyte = stat;
      OPC_RELEASE:  nbyte = DEVICE_CODE;
      OPC_MAKER_ID: nbyte = r.idx[0] ? DEVICE_CODE : MAKER_CODE;
      OPC_JEDEC_ID: begin
        case (r.idx)
          2'h0:    nbyte = MAKER_CODE;
          2'h1:    nbyte = TYPE_CODE;
          2'h2:    nbyte = CAP_CODE;
          default: nbyte = 8'h00;
        endcase
      end
      default:      nbyte = array_data;
    endcase
  end

  // ----------------------------------------
  // Instruction engine
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    next_r.pvalid = 1'b0;
    shin_n = {r.shin[6:0], lk.din};
    bn = (r.bytec == BYTE_SAT) ? r.bytec : r.bytec + 3'h1;
    ok = 1'b0;
    go_out = 1'b0;
    do_start = 1'b0;
    kind_v = OP_PROG;
    if (op_done && r.busy) begin
      next_r.busy = 1'b0;
      next_r.wl = 1'b0;
    end
    if (r.pend) begin
      // Array data must follow array_addr within the same cycle
      next_r.pend = 1'b0;
      next_r.shout = nbyte;
      next_r.idx = (r.idx == IDX_LAST) ? r.idx : r.idx + 2'h1;
      if (r.opc == OPC_READ || r.opc == OPC_FAST || r.opc == OPC_DUAL) begin
        next_r.addr = r.addr + 24'h1;
      end
    end
    if (lk.cs_fall) begin
      next_r.st = S_OPC;
      next_r.bitc = 3'h0;
      next_r.bytec = 3'h0;
      next_r.pcnt = '0;
    end else if (lk.cs_rise) begin
      if (r.opc == OPC_RELEASE && (r.st == S_IN || r.st == S_OUT)) begin
        next_r.pd = 1'b0;
      end
      if (r.st == S_IN && r.bitc == 3'h0) begin
        case (r.opc)
          OPC_WL_SET:  next_r.wl = 1'b1;
          OPC_WL_CLR:  next_r.wl = 1'b0;
          OPC_PDOWN:   next_r.pd = 1'b1;
          OPC_WR_STAT: begin
            if (r.bytec != 3'h0 && r.wl && (!r.lock || lk.wp_b)) begin
              next_r.lock = r.wdata[ST_LOCK];
              next_r.low_end = r.wdata[ST_LOW_END];
              next_r.prot = r.wdata[ST_PROT_HI:ST_PROT_LO];
              do_start = 1'b1;
              kind_v = OP_WR_STAT;
            end
          end
          OPC_PROG: begin
            do_start = r.bytec > ADDR_BYTES && r.wl && !prot_hit;
            kind_v = OP_PROG;
          end
          OPC_SEC_ER: begin
            do_start = r.bytec >= ADDR_BYTES && r.wl && !prot_hit;
            kind_v = OP_SEC_ER;
          end
          OPC_BLK_ER: begin
            do_start = r.bytec >= ADDR_BYTES && r.wl && !prot_hit;
            kind_v = OP_BLK_ER;
          end
          OPC_CHIP_ER: begin
            do_start = r.wl && !prot_hit;
            kind_v = OP_CHIP_ER;
          end
          default: ;
        endcase
      end
      if (do_start) begin
        next_r.start = 1'b1;
        next_r.busy = 1'b1;
        next_r.kind = kind_v;
      end
      next_r.st = S_IDLE;
      next_r.oe = 1'b0;
      next_r.dual = 1'b0;
      next_r.pend = 1'b0;
    end else if (lk.cs_low && lk.sclk_rise && r.st != S_IDLE) begin
      next_r.shin = shin_n;
      next_r.bitc = r.bitc + 3'h1;
      if (r.bitc == BIT_LAST) begin
        unique case (r.st)
          S_OPC: begin
            // Unknown codes and blocked codes fall through to skip
            ok = (shin_n == OPC_WL_SET || shin_n == OPC_WL_CLR ||
                  shin_n == OPC_RD_STAT || shin_n == OPC_WR_STAT ||
                  shin_n == OPC_READ || shin_n == OPC_FAST ||
                  shin_n == OPC_DUAL || shin_n == OPC_PROG ||
                  shin_n == OPC_BLK_ER || shin_n == OPC_SEC_ER ||
                  shin_n == OPC_CHIP_ER || shin_n == OPC_PDOWN ||
                  shin_n == OPC_RELEASE || shin_n == OPC_MAKER_ID ||
                  shin_n == OPC_JEDEC_ID) &&
                 (!r.busy || shin_n == OPC_RD_STAT) &&
                 (!r.pd || shin_n == OPC_RELEASE);
            next_r.opc = shin_n;
            next_r.st = ok ? S_IN : S_SKIP;
            go_out = ok && (shin_n == OPC_RD_STAT || shin_n == OPC_JEDEC_ID);
          end
          S_IN: begin
            next_r.bytec = bn;
            if (bn <= ADDR_BYTES) begin
              next_r.addr = {r.addr[15:0], shin_n};
            end
            if (r.opc == OPC_WR_STAT && bn == 3'h1) begin
              next_r.wdata = shin_n;
            end
            if (r.opc == OPC_PROG && bn > ADDR_BYTES && r.pcnt < PAGE_BYTES) begin
              next_r.pvalid = 1'b1;
              next_r.pdata = shin_n;
              next_r.pcnt = r.pcnt + 1'b1;
            end
            go_out = ((r.opc == OPC_READ || r.opc == OPC_RELEASE ||
                       r.opc == OPC_MAKER_ID) && bn == OUT_AT_RD) ||
                     ((r.opc == OPC_FAST || r.opc == OPC_DUAL) && bn == OUT_AT_FST);
            next_r.dual = r.opc == OPC_DUAL;
          end
          S_OUT, S_SKIP, S_IDLE: ;
        endcase
      end
      if (go_out) begin
        next_r.st = S_OUT;
        next_r.pend = 1'b1;
        next_r.obit = 3'h0;
        next_r.idx = 2'h0;
      end
    end else if (lk.cs_low && lk.sclk_fall && r.st == S_OUT) begin
      next_r.oe = 1'b1;
      next_r.dout = r.shout[7];
      next_r.serial_in_io = r.shout[6];
      if (r.obit == (r.dual ? DUAL_LAST : BIT_LAST)) begin
        next_r.obit = 3'h0;
        next_r.pend = 1'b1;
      end else begin
        next_r.obit = r.obit + 3'h1;
        next_r.shout = r.dual ? {r.shout[5:0], 2'b00} : {r.shout[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign serial_out_o    = r.dout;
  assign serial_out_oe   = r.oe;
  assign serial_in_io_o  = r.serial_in_io;
  assign serial_in_io_oe = r.oe & r.dual;
  assign op_start        = r.start;
  assign op_kind         = r.kind;
  assign op_addr         = r.addr;
  assign prog_valid      = r.pvalid;
  assign prog_data       = r.pdata;
  assign array_addr      = r.addr;
  assign status_byte     = stat;
  assign power_down      = r.pd;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_cs_restart;
    lk.cs_fall |=> r.st == S_OPC && r.bitc == 3'h0 && r.bytec == 3'h0;
  endproperty
  a_cs_restart: assert property (p_cs_restart)
    else $error("counters not restarted at select fall");
  property p_end_quiet;
    lk.cs_rise |=> !serial_out_oe && !serial_in_io_oe && r.st == S_IDLE;
  endproperty
  a_end_quiet: assert property (p_end_quiet)
    else $error("output still driven after select rise");
  property p_aligned;
    op_start |-> $past(lk.cs_rise) && $past(r.bitc) == 3'h0;
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("operation started off a byte boundary");
  property p_need_latch;
    op_start |-> $past(r.wl);
  endproperty
  a_need_latch: assert property (p_need_latch)
    else $error("operation started without write latch");
  property p_busy_hold;
    op_start ##1 !op_done |-> r.busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy not held during operation");
  property p_done_clear;
    r.busy && op_done |=> !r.busy && !r.wl;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("latch or busy not cleared at completion");
  property p_busy_block;
    r.busy && $past(r.busy) |-> !op_start;
  endproperty
  a_busy_block: assert property (p_busy_block)
    else $error("new operation while busy");
  property p_lockout;
    op_start && op_kind == OP_WR_STAT |-> $past(!r.lock || lk.wp_b);
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("status write passed while locked");
  property p_latch_set;
    $rose(r.wl) |-> $past(lk.cs_rise) && $past(r.opc) == OPC_WL_SET;
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("write latch set by the wrong event");
  property p_guarded;
    op_start && op_kind != OP_WR_STAT |-> !$past(prot_hit);
  endproperty
  a_guarded: assert property (p_guarded)
    else $error("guarded address was started");

  c_dual: cover property (serial_in_io_oe && lk.sclk_fall);
  c_stat_loop: cover property (r.opc == OPC_RD_STAT && r.idx == IDX_LAST && r.oe);
  c_prog: cover property (op_start && op_kind == OP_PROG);
  c_wstat: cover property (op_start && op_kind == OP_WR_STAT);
endmodule // sfcfe_top

/* rtl/sfcfe_pkg.sv */
package sfcfe_pkg;
  // ----------------------------------------
  // Instruction codes
  // ----------------------------------------
  localparam logic [7:0] OPC_WL_SET   = 8'h06;
  localparam logic [7:0] OPC_WL_CLR   = 8'h04;
  localparam logic [7:0] OPC_RD_STAT  = 8'h05;
  localparam logic [7:0] OPC_WR_STAT  = 8'h01;
  localparam logic [7:0] OPC_READ     = 8'h03;
  localparam logic [7:0] OPC_FAST     = 8'h0B;
  localparam logic [7:0] OPC_DUAL     = 8'h3B;
  localparam logic [7:0] OPC_PROG     = 8'h02;
  localparam logic [7:0] OPC_BLK_ER   = 8'hD8;
  localparam logic [7:0] OPC_SEC_ER   = 8'h20;
  localparam logic [7:0] OPC_CHIP_ER  = 8'hC7;
  localparam logic [7:0] OPC_PDOWN    = 8'hB9;
  localparam logic [7:0] OPC_RELEASE  = 8'hAB;
  localparam logic [7:0] OPC_MAKER_ID = 8'h90;
  localparam logic [7:0] OPC_JEDEC_ID = 8'h9F;
  // ----------------------------------------
  // Status byte layout
  // ----------------------------------------
  localparam int ST_BUSY    = 0;
  localparam int ST_WL      = 1;
  localparam int ST_PROT_LO = 2;
  localparam int ST_PROT_HI = 4;
  localparam int ST_LOW_END = 5;
  localparam int ST_LOCK    = 7;
  // ----------------------------------------
  // Framing counts
  // ----------------------------------------
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [2:0] DUAL_LAST  = 3'h3;
  localparam logic [2:0] BYTE_SAT   = 3'h7;
  localparam logic [2:0] ADDR_BYTES = 3'h3;
  localparam logic [2:0] OUT_AT_RD  = 3'h3;
  localparam logic [2:0] OUT_AT_FST = 3'h4;
  localparam logic [1:0] IDX_LAST   = 2'h3;
  // ----------------------------------------
  // Protection map
  // ----------------------------------------
  localparam int         BLK_LSB      = 16;
  localparam logic [6:0] BLKS_32M     = 7'h40;
  localparam logic [6:0] BLKS_16M     = 7'h20;
  localparam logic [6:0] PROT_ONE_BLK = 7'h01;
  localparam logic [2:0] PROT_NONE    = 3'h0;
  localparam logic [2:0] PROT_ALL     = 3'h7;
  localparam logic [2:0] PROT_ALL_16M = 3'h6;
  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------
  localparam int         PIN_SCLK = 0;
  localparam int         PIN_CS   = 1;
  localparam int         PIN_DIN  = 2;
  localparam int         PIN_WP   = 3;
  localparam logic [3:0] SYNC_RST = 4'hA;

  typedef enum logic [2:0] {OP_PROG, OP_SEC_ER, OP_BLK_ER, OP_CHIP_ER, OP_WR_STAT} sfcfe_op_t;
  typedef enum logic [2:0] {S_IDLE, S_OPC, S_IN, S_OUT, S_SKIP} sfcfe_state_t;
endpackage

/* rtl/sfcfe_link_if.sv */
`timescale 1ns/1ps
interface sfcfe_link_if;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic cs_low;
  logic din;
  logic wp_b;
  modport src (output sclk_rise, sclk_fall, cs_fall, cs_rise, cs_low, din, wp_b);
  modport snk (input sclk_rise, sclk_fall, cs_fall, cs_rise, cs_low, din, wp_b);
endinterface // sfcfe_link_if

/* rtl/sfcfe_pin_sync.sv */
`timescale 1ns/1ps
module sfcfe_pin_sync (
  input  wire logic  clk_sys,
  input  wire logic  rst_b,
  input  wire logic  sclk,
  input  wire logic  cs_b,
  input  wire logic  din_pin,
  input  wire logic  wp_pin,
  sfcfe_link_if.src  lk
);
  import sfcfe_pkg::*;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
  } sfcfe_sync_t;

  sfcfe_sync_t r;
  sfcfe_sync_t next_r;

  // ----------------------------------------
  // Two stages, third only for edges
  // ----------------------------------------
  always_comb begin
    next_r.s1 = {wp_pin, din_pin, cs_b, sclk};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r <= {3{SYNC_RST}};
    end else begin
      r <= next_r;
    end
  end

  // Data travels with the clock, so both share the same latency
  assign lk.sclk_rise = r.s2[PIN_SCLK] & ~r.s3[PIN_SCLK];
  assign lk.sclk_fall = ~r.s2[PIN_SCLK] & r.s3[PIN_SCLK];
  assign lk.cs_fall   = ~r.s2[PIN_CS] & r.s3[PIN_CS];
  assign lk.cs_rise   = r.s2[PIN_CS] & ~r.s3[PIN_CS];
  assign lk.cs_low    = ~r.s2[PIN_CS];
  assign lk.din       = r.s2[PIN_DIN];
  assign lk.wp_b      = r.s2[PIN_WP];
endmodule // sfcfe_pin_sync

/* rtl/sfcfe_protect.sv */
`timescale 1ns/1ps
module sfcfe_protect (
  input  wire logic [23:0] addr,
  input  wire logic [2:0]  prot,
  input  wire logic        low_end,
  input  wire logic        dens_32m,
  input  wire logic        chip,
  output logic             hit
);
  import sfcfe_pkg::*;

  logic [6:0] blk;
  logic [6:0] total;
  logic [6:0] span;
  logic       all_guard;

  // ----------------------------------------
  // Guarded span in 64KB blocks
  // ----------------------------------------
  always_comb begin
    if (dens_32m) begin
      blk   = {1'b0, addr[BLK_LSB+5:BLK_LSB]};
      total = BLKS_32M;
    end else begin
      blk   = {2'b00, addr[BLK_LSB+4:BLK_LSB]};
      total = BLKS_16M;
    end
    span      = PROT_ONE_BLK << (prot - 3'h1);
    all_guard = (prot == PROT_ALL) || (!dens_32m && prot >= PROT_ALL_16M);
    if (prot == PROT_NONE) begin
      hit = 1'b0;
    end else if (all_guard || chip) begin
      // Whole-array erase is refused if any part is guarded
      hit = 1'b1;
    end else if (low_end) begin
      hit = blk < span;
    end else begin
      hit = blk >= (total - span);
    end
  end
endmodule // sfcfe_protect

/* tb/sfcfe_host.sv */
`timescale 1ns/1ps
module sfcfe_host (
  input  wire logic clk_sys,
  input  wire logic dout,
  input  wire logic io_in,
  output logic      sclk,
  output logic      cs_b,
  output logic      din,
  output logic      din_oe
);
  // ----------------------------------------
  // Mode 0 master, clock still between frames
  // ----------------------------------------
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    din = 1'b0;
    din_oe = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic open_frame();
    wait_clk(1);
    cs_b <= 1'b0;
    din_oe <= 1'b1;
    wait_clk(4);
  endtask
  // Sample just before the next fall: output lags the fall by a few clocks
  task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      sclk <= 1'b0;
      din <= tx[i];
      wait_clk(4);
      sclk <= 1'b1;
      wait_clk(4);
      rx[i] = dout;
    end
  endtask
  // Line released first so the device may take it
  task automatic dual(output logic [7:0] rx);
    din_oe <= 1'b0;
    for (int i = 3; i >= 0; i--) begin
      sclk <= 1'b0;
      wait_clk(4);
      sclk <= 1'b1;
      wait_clk(4);
      rx[2*i+1] = dout;
      rx[2*i] = io_in;
    end
  endtask
  task automatic close_frame();
    sclk <= 1'b0;
    wait_clk(4);
    cs_b <= 1'b1;
    din_oe <= 1'b0;
    wait_clk(10);
  endtask
endmodule // sfcfe_host

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import sfcfe_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_sys, rst_b, sclk, cs_b, h_din, h_oe, io_o, io_oe;
  logic        out_o, out_oe, io_wire, out_wire, wp_b, op_done, op_start;
  logic        prog_valid, power_down, dens;
  logic        idle_tog = 1'b0;
  sfcfe_op_t   op_kind;
  logic [23:0] op_addr, array_addr;
  logic [7:0]  prog_data, array_data, status_byte, rx, last_prog;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          n_op = 0;
  int          n_prog = 0;
  // ----------------------------------------
  // Clock, wires, far-side models
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Undriven lines wander so a stale value never passes
  always @(posedge clk_sys) idle_tog <= ~idle_tog;
  assign io_wire    = io_oe ? io_o : (h_oe ? h_din : idle_tog);
  assign out_wire   = out_oe ? out_o : idle_tog;
  assign array_data = array_addr[7:0] ^ array_addr[15:8];
  always @(posedge clk_sys) begin
    if (op_start) n_op <= n_op + 1;
    if (prog_valid) begin
      n_prog <= n_prog + 1;
      last_prog <= prog_data;
    end
  end
  sfcfe_top uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
    .serial_in_io_i(io_wire), .serial_in_io_o(io_o), .serial_in_io_oe(io_oe),
    .serial_out_o(out_o), .serial_out_oe(out_oe), .write_protect_b(wp_b),
    .dens_32m(dens), .op_done(op_done), .op_start(op_start), .op_kind(op_kind),
    .op_addr(op_addr), .prog_valid(prog_valid), .prog_data(prog_data),
    .array_addr(array_addr), .array_data(array_data), .status_byte(status_byte),
    .power_down(power_down)
  );
  sfcfe_host h (
    .clk_sys(clk_sys), .dout(out_wire), .io_in(io_wire), .sclk(sclk),
    .cs_b(cs_b), .din(h_din), .din_oe(h_oe)
  );
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Bytes leave high first; any byte past the third is a zero dummy
  task automatic start(input logic [7:0] op, input logic [23:0] a, input int n);
    logic [31:0] sr;
    sr = {a, 8'h00};
    h.open_frame();
    h.shift(op, 8, rx);
    repeat (n) begin
      h.shift(sr[31:24], 8, rx);
      sr = sr << 8;
    end
  endtask
  task automatic frame1(input logic [7:0] op);
    start(op, 24'h0, 0);
    h.close_frame();
  endtask
  task automatic wstat(input logic [7:0] d);
    frame1(8'h06);
    start(8'h01, {d, 16'h0}, 1);
    h.close_frame();
  endtask
  task automatic rd(input string what, input logic [7:0] exp);
    h.shift(8'h00, 8, rx);
    chk(what, rx, exp);
  endtask
  task automatic finish_op();
    @(posedge clk_sys) op_done <= 1'b1;
    @(posedge clk_sys) op_done <= 1'b0;
    h.wait_clk(4);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_latch();
    start(8'h05, 24'h0, 0);
    rd("status at reset", 8'h00);
    h.close_frame();
    frame1(8'h06);
    chk("latch set", status_byte, 8'h02);
    frame1(8'h04);
    chk("latch clear", status_byte, 8'h00);
    wstat(8'h00);
    finish_op();
    frame1(8'h04);
    start(8'h01, 24'h1C0000, 1);
    h.close_frame();
    chk("unlatched status write", n_op[23:0], 24'h1);
    start(8'hFF, 24'h0, 1);
    chk("unknown opcode quiet", out_oe, 1'b0);
    h.close_frame();
    finish_op();
    $display("test latch done");
  endtask
  task automatic t_wstat();
    wstat(8'h67);
    chk("status write start", n_op[23:0], 24'h2);
    chk("status write kind", 24'(op_kind), 24'(OP_WR_STAT));
    start(8'h05, 24'h0, 0);
    rd("busy status", 8'h27);
    rd("status repeat", 8'h27);
    h.close_frame();
    frame1(8'h04);
    chk("busy ignores clear", status_byte, 8'h27);
    finish_op();
    chk("status after cycle", status_byte, 8'h24);
    frame1(8'h06);
    start(8'h01, 24'h0, 0);
    h.shift(8'h00, 7, rx);
    h.close_frame();
    chk("partial byte dropped", n_op[23:0], 24'h2);
    chk("latch kept", status_byte, 8'h26);
    $display("test status write done");
  endtask
  task automatic t_read();
    start(8'h03, 24'h123456, 3);
    rd("read byte 0", 8'h62);
    rd("read byte 1", 8'h63);
    h.shift(8'h00, 3, rx);
    h.close_frame();
    chk("read cut mid byte", out_oe, 1'b0);
    start(8'h0B, 24'h001020, 4);
    rd("fast read", 8'h30);
    h.close_frame();
    start(8'h3B, 24'h002041, 4);
    h.dual(rx);
    chk("dual byte 0", rx, 8'h61);
    h.dual(rx);
    chk("dual byte 1", rx, 8'h62);
    h.close_frame();
    $display("test read done");
  endtask
  task automatic t_protect();
    start(8'hD8, 24'h00FFFF, 3);
    h.close_frame();
    start(8'hC7, 24'h0, 0);
    h.close_frame();
    chk("guarded erase dropped", n_op[23:0], 24'h2);
    start(8'hD8, 24'h010000, 3);
    h.close_frame();
    chk("open block erase", n_op[23:0], 24'h3);
    chk("block erase addr", op_addr, 24'h010000);
    chk("block erase kind", 24'(op_kind), 24'(OP_BLK_ER));
    finish_op();
    chk("latch after erase", status_byte, 8'h24);
    start(8'h20, 24'h020000, 3);
    h.close_frame();
    chk("erase needs latch", n_op[23:0], 24'h3);
    frame1(8'h06);
    start(8'h20, 24'h3F1000, 3);
    h.close_frame();
    chk("sector erase kind", 24'(op_kind), 24'(OP_SEC_ER));
    finish_op();
    frame1(8'h06);
    start(8'h02, 24'h012300, 3);
    h.shift(8'hA5, 8, rx);
    h.shift(8'h5A, 8, rx);
    h.close_frame();
    chk("program bytes", n_prog[23:0], 24'h2);
    chk("program last", last_prog, 8'h5A);
    chk("program kind", 24'(op_kind), 24'(OP_PROG));
    finish_op();
    $display("test protect done");
  endtask
  task automatic t_ids();
    start(8'h9F, 24'h0, 0);
    rd("jedec maker", 8'h5A);
    rd("jedec type", 8'h71);
    rd("jedec capacity", 8'h17);
    h.close_frame();
    start(8'h90, 24'h0, 3);
    rd("maker code", 8'h5A);
    rd("device code", 8'h3C);
    h.close_frame();
    frame1(8'hB9);
    chk("power down", power_down, 1'b1);
    start(8'h05, 24'h0, 1);
    chk("asleep stays quiet", out_oe, 1'b0);
    h.close_frame();
    start(8'hAB, 24'h0, 3);
    rd("release id", 8'h3C);
    rd("release id again", 8'h3C);
    h.close_frame();
    chk("awake", power_down, 1'b0);
    $display("test ids done");
  endtask
  task automatic t_lock();
    wstat(8'h80);
    finish_op();
    @(posedge clk_sys) wp_b <= 1'b0;
    wstat(8'h00);
    chk("locked status write", n_op[23:0], 24'h6);
    chk("lock kept", status_byte, 8'h82);
    @(posedge clk_sys) wp_b <= 1'b1;
    wstat(8'h00);
    finish_op();
    chk("unlocked write", status_byte, 8'h00);
    $display("test lock done");
  endtask
  task automatic t_dens();
    wstat(8'h18);
    finish_op();
    @(posedge clk_sys) dens <= 1'b0;
    frame1(8'h06);
    start(8'hD8, 24'h000000, 3);
    h.close_frame();
    chk("small part all guarded", n_op[23:0], 24'h8);
    @(posedge clk_sys) dens <= 1'b1;
    start(8'hD8, 24'h3F0000, 3);
    h.close_frame();
    chk("top half guarded", n_op[23:0], 24'h8);
    start(8'hD8, 24'h000000, 3);
    h.close_frame();
    chk("bottom half open", n_op[23:0], 24'h9);
    finish_op();
    $display("test density done");
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    stop_test();
  end
  initial begin
    rst_b = 1'b0;
    wp_b = 1'b1;
    dens = 1'b1;
    op_done = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    h.wait_clk(4);
    t_latch();
    t_wstat();
    t_read();
    t_protect();
    t_ids();
    t_lock();
    t_dens();
    stop_test();
  end
endmodule // tb_top
